// File: dv/cmd_side_model.sv
`timescale 1ns/10ps
module cmd_side_model (
    input  wire logic       hclk,
    output logic            timer_zero,
    output logic            tx_end_of_frame,
    output logic            rx_end,
    output logic      [6:0] link_errors,
    output logic            cmd_finished,
    output logic            cmd_pop,
    output logic            cmd_push,
    output logic      [7:0] cmd_push_data
);
    initial begin
        timer_zero      = 1'h0;
        tx_end_of_frame = 1'h0;
        rx_end          = 1'h0;
        link_errors     = 7'h00;
        cmd_finished    = 1'h0;
        cmd_pop         = 1'h0;
        cmd_push        = 1'h0;
        cmd_push_data   = 8'h00;
    end
    // one source event per call, queue touched only on request
    task automatic fire(input int k, input logic [6:0] v);
        @(posedge hclk);
        case (k)
            0: timer_zero <= 1'h1;
            1: tx_end_of_frame <= 1'h1;
            2: rx_end <= 1'h1;
            3: cmd_finished <= 1'h1;
            4: link_errors <= v;
            5: begin
                cmd_push      <= 1'h1;
                cmd_push_data <= {1'h0, v};
            end
            default: cmd_pop <= 1'h1;
        endcase
        @(posedge hclk);
        timer_zero    <= 1'h0;
        cmd_finished  <= 1'h0;
        link_errors   <= 7'h00;
        cmd_push      <= 1'h0;
        cmd_pop       <= 1'h0;
        cmd_push_data <= ~cmd_push_data;
        repeat (2) @(posedge hclk);
        tx_end_of_frame <= 1'h0;
        rx_end          <= 1'h0;
    endtask
endmodule

// File: dv/fifo_crc_irq_unit_asserts.sv
`timescale 1ns/10ps
module fifo_crc_irq_unit_asserts
    import fifo_crc_irq_pkg::*;
#(
    parameter int DEPTH = QUEUE_DEPTH
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        timer_zero,
    input wire logic [6:0]  link_errors,
    input wire logic        irq_pin
);
    logic       en_pend;
    logic [7:0] en_q;
    logic       rd_ph;
    assign rd_ph = hsel && htrans[1] && !hwrite && hready;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////
    // shadow of the event enable register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_pend <= 1'h0;
        end else if (hready) begin
            en_pend <= hsel && htrans[1] && hwrite && haddr[7:0] == ADDR_EVENT_EN;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_q <= 8'h00;
        end else if (en_pend && hready) begin
            en_q <= hwdata[7:0];
        end
    end
    ////////////////////////////////////////
    chk_read_hold:
        assert property (!rd_ph |=> $stable(hrdata)) else $error("read data moved");
    chk_fill_width:
        assert property (rd_ph && haddr[7:0] == ADDR_QUEUE_FILL |=> hrdata[31:7] == 25'h0)
        else $error("fill read wider than count");
    chk_level_width:
        assert property (rd_ph && haddr[7:0] == ADDR_THRESHOLD |=> hrdata[31:6] == 26'h0)
        else $error("threshold read wider than six bits");
    chk_cmd_width:
        assert property (rd_ph && haddr[7:0] == ADDR_COMMAND |=> hrdata[31:4] == 28'h0)
        else $error("command read wider than four bits");
    chk_crc_bytes:
        assert property (rd_ph && (haddr[7:0] == ADDR_CRC_HI || haddr[7:0] == ADDR_CRC_LO)
            |=> hrdata[31:8] == 24'h0) else $error("checksum byte wider than eight bits");
    chk_irq_quiet:
        assert property (en_q == 8'h00 [*2] |-> !irq_pin) else $error("pin up with none enabled");
    chk_timer_irq:
        assert property (en_q == 8'h01 && timer_zero |-> ##[1:2] irq_pin)
        else $error("timer event missed pin");
    chk_error_irq:
        assert property (en_q == 8'h02 && link_errors != 7'h00 |-> ##[1:3] irq_pin)
        else $error("error event missed pin");
endmodule

bind fifo_crc_irq_unit fifo_crc_irq_unit_asserts #(.DEPTH(DEPTH)) chk_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .timer_zero(timer_zero), .link_errors(link_errors), .irq_pin(irq_pin)
);

// File: dv/tb.sv
`timescale 1ns/10ps
module tb import fifo_crc_irq_pkg::*;;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        timer_zero;
    logic        tx_end_of_frame;
    logic        rx_end;
    logic [6:0]  link_errors;
    logic        cmd_finished;
    logic        cmd_pop;
    logic        cmd_push;
    logic [7:0]  cmd_push_data;
    logic [7:0]  pop_data;
    logic        irq_pin;
    logic [31:0] rv;
    logic [15:0] crc;
    int          bad_count;
    int          comparisons;
    int          bits [5] = '{BIT_TIMER, BIT_TX, BIT_RX, BIT_IDLE, BIT_ERR};
    logic [15:0] seeds [4] = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFF};
    fifo_crc_irq_unit dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .timer_zero(timer_zero),
        .tx_end_of_frame(tx_end_of_frame), .rx_end(rx_end), .link_errors(link_errors),
        .cmd_finished(cmd_finished), .cmd_pop(cmd_pop), .cmd_push(cmd_push),
        .cmd_push_data(cmd_push_data), .cmd_pop_data(pop_data), .irq_pin(irq_pin)
    );
    cmd_side_model model_u (
        .hclk(hclk), .timer_zero(timer_zero), .tx_end_of_frame(tx_end_of_frame),
        .rx_end(rx_end), .link_errors(link_errors), .cmd_finished(cmd_finished),
        .cmd_pop(cmd_pop), .cmd_push(cmd_push), .cmd_push_data(cmd_push_data)
    );
    ////////////////////////////////////////
    task automatic print_verdict();
        $display("compares=%0d mismatches=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h000000, a};
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rv = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'h1, a, {24'h000000, d});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'h0, a, 32'h00000000);
        check(rv & m, e);
    endtask
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        for (int i = 7; i >= 0; i--) c = {c[14:0], 1'h0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0);
        return c;
    endfunction
    ////////////////////////////////////////
    initial begin
        hclk = 1'h0;
        forever #25 hclk = ~hclk;
    end
    initial begin
        repeat (30000) @(posedge hclk);
        bad_count++;
        print_verdict();
    end
    initial begin
        hresetn = 1'h0;
        hsel    = 1'h0;
        haddr   = 32'h0;
        htrans  = 2'h0;
        hwrite  = 1'h0;
        hwdata  = 32'h0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'h1;
        rdc(ADDR_THRESHOLD, 32'hFF, 32'h08);
        rdc(ADDR_STATUS, 32'h3, 32'h1);
        wr(ADDR_EVENT_FLAG, 8'h7F);
        wr(ADDR_EVENT_EN, 8'h08);
        for (int i = 1; i <= QUEUE_DEPTH; i++) begin
            wr(ADDR_QUEUE_DATA, 8'(i) ^ 8'hA5);
            rdc(ADDR_QUEUE_FILL, 32'hFF, 32'(i));
            rdc(ADDR_STATUS, 32'h3, {30'h0, QUEUE_DEPTH - i <= 8, i <= 8});
        end
        check({31'h0, irq_pin}, 32'h1);
        rdc(ADDR_EVENT_FLAG, 32'h0C, 32'h08);
        wr(ADDR_QUEUE_DATA, 8'h3C);
        rdc(ADDR_QUEUE_FILL, 32'hFF, 32'h40);
        rdc(ADDR_ERROR, 32'h10, 32'h10);
        for (int i = 1; i <= QUEUE_DEPTH; i++) begin
            rdc(ADDR_QUEUE_DATA, 32'hFF, 32'(8'(i) ^ 8'hA5));
        end
        rdc(ADDR_QUEUE_FILL, 32'hFF, 32'h0);
        rdc(ADDR_ERROR, 32'h10, 32'h10);
        rdc(ADDR_EVENT_FLAG, 32'h0C, 32'h0C);
        wr(ADDR_EVENT_FLAG, 8'h08);
        wr(ADDR_EVENT_EN, 8'h04);
        repeat (2) @(posedge hclk);
        check({31'h0, irq_pin}, 32'h1);
        wr(ADDR_QUEUE_DATA, 8'h11);
        wr(ADDR_QUEUE_FILL, 8'h80);
        rdc(ADDR_QUEUE_FILL, 32'hFF, 32'h0);
        rdc(ADDR_ERROR, 32'h10, 32'h0);
        wr(ADDR_EVENT_FLAG, 8'h7F);
        repeat (2) @(posedge hclk);
        check({31'h0, irq_pin}, 32'h0);
        wr(ADDR_COMMAND, 8'h0C);
        for (int k = 0; k < 5; k++) begin
            wr(ADDR_EVENT_EN, 8'(1 << bits[k]));
            wr(ADDR_EVENT_FLAG, 8'h7F);
            model_u.fire(k, 7'h05);
            rdc(ADDR_EVENT_FLAG, 32'h73, 32'(1 << bits[k]));
            check({31'h0, irq_pin}, 32'h1);
        end
        rdc(ADDR_COMMAND, 32'hF, 32'h0);
        model_u.fire(5, 7'h2A);
        rdc(ADDR_QUEUE_FILL, 32'hFF, 32'h1);
        rdc(ADDR_QUEUE_DATA, 32'hFF, 32'h2A);
        wr(ADDR_QUEUE_DATA, 8'h5A);
        repeat (2) @(posedge hclk);
        check({24'h0, pop_data}, 32'h5A);
        model_u.fire(6, 7'h00);
        rdc(ADDR_QUEUE_FILL, 32'hFF, 32'h0);
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_MODE, 8'h08 | 8'(s));
            wr(ADDR_QUEUE_DATA, 8'h31);
            wr(ADDR_CRC_START, 8'h01);
            rv = 32'h1;
            for (int n = 0; n < 20 && rv[0] === 1'h1; n++) bus(1'h0, ADDR_CRC_START, 32'h0);
            crc = crc_byte(seeds[s], 8'h31);
            rdc(ADDR_STATUS, 32'h4, 32'h4);
            rdc(ADDR_MISC_EVENT, 32'h4, 32'h4);
            rdc(ADDR_CRC_HI, 32'hFF, {24'h0, crc[15:8]});
            rdc(ADDR_CRC_LO, 32'hFF, {24'h0, crc[7:0]});
            wr(ADDR_MISC_EVENT, 8'h04);
        end
        print_verdict();
    end
endmodule

// File: hdl/fifo_crc_irq_pkg.sv
package fifo_crc_irq_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_QUEUE_DATA  = 8'h00;
    localparam logic [7:0] ADDR_QUEUE_FILL  = 8'h04;
    localparam logic [7:0] ADDR_THRESHOLD   = 8'h08;
    localparam logic [7:0] ADDR_STATUS      = 8'h0C;
    localparam logic [7:0] ADDR_ERROR       = 8'h10;
    localparam logic [7:0] ADDR_EVENT_EN    = 8'h14;
    localparam logic [7:0] ADDR_EVENT_FLAG  = 8'h18;
    localparam logic [7:0] ADDR_MISC_EVENT  = 8'h1C;
    localparam logic [7:0] ADDR_MODE        = 8'h20;
    localparam logic [7:0] ADDR_CRC_HI      = 8'h24;
    localparam logic [7:0] ADDR_CRC_LO      = 8'h28;
    localparam logic [7:0] ADDR_COMMAND     = 8'h2C;
    localparam logic [7:0] ADDR_CRC_START   = 8'h30;
    // event flag and event enable bit positions
    localparam int BIT_TIMER      = 0;
    localparam int BIT_ERR        = 1;
    localparam int BIT_NEAR_EMPTY = 2;
    localparam int BIT_NEAR_FULL  = 3;
    localparam int BIT_IDLE       = 4;
    localparam int BIT_RX         = 5;
    localparam int BIT_TX         = 6;
    localparam int BIT_IRQ_INV    = 7;
    // other field positions
    localparam int BIT_FLUSH      = 7;
    localparam int BIT_OVFL       = 4;
    localparam int BIT_CRC_READY  = 5;
    localparam int BIT_CRC_EVENT  = 2;
    localparam int BIT_HIGH_FIRST = 3;
    localparam int BIT_STAT_IRQ   = 4;
    localparam int BIT_STAT_FULL  = 1;
    localparam int BIT_STAT_EMPTY = 0;
    localparam int QUEUE_DEPTH    = 64;
    localparam logic [7:0]  THRESHOLD_RESET = 8'h08;
    localparam logic [7:0]  MODE_RESET      = 8'h3F;
    localparam logic [3:0]  CMD_IDLE        = 4'h0;
    localparam logic [15:0] CRC_POLY        = 16'h1021;
    localparam logic [15:0] SEED_0          = 16'h0000;
    localparam logic [15:0] SEED_1          = 16'h6363;
    localparam logic [15:0] SEED_2          = 16'hA671;
    localparam logic [15:0] SEED_3          = 16'hFFFF;
endpackage

// File: hdl/fifo_crc_irq_unit.sv
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
module fifo_crc_irq_unit
    import fifo_crc_irq_pkg::*;
#(
    parameter int DEPTH = QUEUE_DEPTH
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        timer_zero,
    input  wire logic        tx_end_of_frame,
    input  wire logic        rx_end,
    input  wire logic [6:0]  link_errors,
    input  wire logic        cmd_finished,
    input  wire logic        cmd_pop,
    input  wire logic        cmd_push,
    input  wire logic [7:0]  cmd_push_data,
    output logic      [7:0]  cmd_pop_data,
    output logic             irq_pin
);

////////////////////////////////////////////////////////////////////////////////
    localparam int PW = $clog2(DEPTH);

    logic [7:0]    mem [DEPTH];
    logic [PW:0]   wr_ptr;
    logic [PW:0]   rd_ptr;
    logic [6:0]    fill;
    logic          overflow_err;
    logic [5:0]    fill_threshold;
    logic [7:0]    event_enable_register;
    logic [6:0]    event_flag_register;
    logic          checksum_done_flag;
    logic          checksum_ready;
    logic          crc_busy;
    logic [15:0]   crc;
    logic [7:0]    general_mode_register;
    logic [3:0]    command_register;
    logic          near_full_q;
    logic          near_empty_q;
    logic          tx_q;
    logic          rx_q;
    logic          ph_valid;
    logic          ph_write;
    logic [7:0]    ph_addr;
    logic [7:0]    link_errors_r;

    wire logic     queue_near_full;
    wire logic     queue_near_empty;
    wire logic     wr_en;
    wire logic     rd_en;
    wire logic     data_wr;
    wire logic     data_rd;
    wire logic     flush;
    wire logic     irq_any;
    wire logic     full;
    wire logic     empty;
    wire logic     crc_take;
    wire logic [7:0] error_flags_register;

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d,
                                             input logic hf);
        logic [15:0] r;
        logic        b;
        r = c;
        for (int i = 0; i < 8; i++) begin
            b = hf ? d[7-i] : d[i];
            r = (r[15] ^ b) ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    function automatic logic [15:0] seed_of(input logic [1:0] sel);
        unique case (sel)
            2'b00: seed_of = SEED_0;
            2'b01: seed_of = SEED_1;
            2'b10: seed_of = SEED_2;
            2'b11: seed_of = SEED_3;
        endcase
    endfunction

////////////////////////////////////////////////////////////////////////////////
    // bus address phase capture, zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr  <= 8'h00;
        end else if (hready) begin
            ph_valid <= hsel & htrans[1];
            ph_write <= hwrite;
            ph_addr  <= haddr[7:0];
        end
    end

    assign wr_en   = ph_valid & ph_write;
    assign rd_en   = hsel & htrans[1] & ~hwrite & hready;
    assign data_wr = wr_en & (ph_addr == ADDR_QUEUE_DATA);
    assign data_rd = rd_en & (haddr[7:0] == ADDR_QUEUE_DATA);
    assign flush   = wr_en & (ph_addr == ADDR_QUEUE_FILL) & hwdata[BIT_FLUSH];
    assign full    = (fill == 7'(DEPTH));
    assign empty   = (fill == 7'h00);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // queue storage and pointers
    wire logic push = (data_wr | cmd_push) & ~full & ~flush;
    wire logic [7:0] push_byte = data_wr ? hwdata[7:0] : cmd_push_data;
    wire logic pop  = (data_rd | cmd_pop | crc_take) & ~empty & ~flush;

    always_ff @(posedge hclk) begin
        if (push) begin
            mem[wr_ptr[PW-1:0]] <= push_byte;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop)  rd_ptr <= rd_ptr + 1'b1;
        end
    end

    assign fill = 7'(wr_ptr - rd_ptr);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_pop_data <= 8'h00;
        end else begin
            cmd_pop_data <= mem[rd_ptr[PW-1:0]];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overflow_err <= 1'b0;
        end else if ((data_wr | cmd_push) & full & ~flush) begin
            overflow_err <= 1'b1;
        end else if (flush) begin
            overflow_err <= 1'b0;
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // alerts
    assign queue_near_full  = (7'(DEPTH) - fill) <= {1'b0, fill_threshold};
    assign queue_near_empty = fill <= {1'b0, fill_threshold};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            near_full_q  <= 1'b0;
            near_empty_q <= 1'b0;
            tx_q         <= 1'b0;
            rx_q         <= 1'b0;
        end else begin
            near_full_q  <= queue_near_full;
            near_empty_q <= queue_near_empty;
            tx_q         <= tx_end_of_frame;
            rx_q         <= rx_end;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link_errors_r <= 8'h00;
        end else begin
            link_errors_r <= {1'b0, link_errors};
        end
    end

    assign error_flags_register = link_errors_r | (8'(overflow_err) << BIT_OVFL);

////////////////////////////////////////////////////////////////////////////////
    // event flags, set beats clear
    wire logic ev_wr  = wr_en & (ph_addr == ADDR_EVENT_FLAG);
    wire logic ev_set = hwdata[7];
    logic [6:0] ev_src;

    always_comb begin
        ev_src                 = '0;
        ev_src[BIT_TIMER]      = timer_zero;
        ev_src[BIT_ERR]        = |error_flags_register;
        ev_src[BIT_NEAR_EMPTY] = queue_near_empty & ~near_empty_q;
        ev_src[BIT_NEAR_FULL]  = queue_near_full & ~near_full_q;
        ev_src[BIT_IDLE]       = cmd_finished;
        ev_src[BIT_RX]         = rx_end & ~rx_q;
        ev_src[BIT_TX]         = tx_end_of_frame & ~tx_q;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_flag_register <= 7'h00;
        end else if (ev_wr) begin
            event_flag_register <= ev_set ? (event_flag_register | hwdata[6:0] | ev_src)
                                          : ((event_flag_register & ~hwdata[6:0]) | ev_src);
        end else begin
            event_flag_register <= event_flag_register | ev_src;
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // checksum engine consumes the queue
    wire logic crc_start = wr_en & (ph_addr == ADDR_CRC_START) & hwdata[0];
    assign crc_take = crc_busy & ~empty;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            crc_busy       <= 1'b0;
            crc            <= SEED_3;
            checksum_ready <= 1'b0;
        end else if (crc_start) begin
            crc_busy       <= 1'b1;
            crc            <= seed_of(general_mode_register[1:0]);
            checksum_ready <= 1'b0;
        end else if (crc_busy) begin
            if (crc_take) begin
                crc <= crc_byte(crc, mem[rd_ptr[PW-1:0]],
                                general_mode_register[BIT_HIGH_FIRST]);
            end else begin
                crc_busy       <= 1'b0;
                checksum_ready <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            checksum_done_flag <= 1'b0;
        end else if (crc_busy & empty) begin
            checksum_done_flag <= 1'b1;
        end else if (wr_en & (ph_addr == ADDR_MISC_EVENT) & ~hwdata[7]
                     & hwdata[BIT_CRC_EVENT]) begin
            checksum_done_flag <= 1'b0;
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fill_threshold        <= THRESHOLD_RESET[5:0];
            event_enable_register <= 8'h00;
            general_mode_register <= MODE_RESET;
            command_register      <= CMD_IDLE;
        end else if (wr_en) begin
            unique case (ph_addr)
                ADDR_THRESHOLD: fill_threshold        <= hwdata[5:0];
                ADDR_EVENT_EN:  event_enable_register <= hwdata[7:0];
                ADDR_MODE:      general_mode_register <= hwdata[7:0];
                ADDR_COMMAND:   command_register      <= hwdata[3:0];
                default:        ;
            endcase
        end else if (cmd_finished) begin
            command_register <= CMD_IDLE;
        end
    end

    assign irq_any = |(event_flag_register & event_enable_register[6:0]) |
                     (checksum_done_flag & checksum_ready);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_pin <= 1'b0;
        end else begin
            irq_pin <= irq_any ^ event_enable_register[BIT_IRQ_INV];
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // read data, one word per aligned address
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_en) begin
            unique case (haddr[7:0])
                ADDR_QUEUE_DATA: hrdata <= {24'h0, mem[rd_ptr[PW-1:0]]};
                ADDR_QUEUE_FILL: hrdata <= {25'h0, fill};
                ADDR_THRESHOLD:  hrdata <= {26'h0, fill_threshold};
                ADDR_STATUS:     hrdata <= {27'h0, irq_any, 1'b0, checksum_ready,
                                            queue_near_full, queue_near_empty};
                ADDR_ERROR:      hrdata <= {24'h0, error_flags_register};
                ADDR_EVENT_EN:   hrdata <= {24'h0, event_enable_register};
                ADDR_EVENT_FLAG: hrdata <= {25'h0, event_flag_register};
                ADDR_MISC_EVENT: hrdata <= {29'h0, checksum_done_flag, 2'b00};
                ADDR_MODE:       hrdata <= {24'h0, general_mode_register};
                ADDR_CRC_HI:     hrdata <= {24'h0, crc[15:8]};
                ADDR_CRC_LO:     hrdata <= {24'h0, crc[7:0]};
                ADDR_COMMAND:    hrdata <= {28'h0, command_register};
                ADDR_CRC_START:  hrdata <= {31'h0, crc_busy};
                default:         hrdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule
